// ---- shared/amd_pkg.sv ----
package amd_pkg;
    // APB register byte offsets
    localparam logic [7:0] CMD_OFS = 8'h00;
    localparam logic [7:0] CFG_OFS = 8'h04;
    localparam logic [7:0] IMM_OFS = 8'h08;
    localparam logic [7:0] FLAG_OFS = 8'h0C;
    localparam logic [7:0] STAT_OFS = 8'h10;
    localparam logic [7:0] MACH_OFS = 8'h14;
    localparam logic [7:0] MACL_OFS = 8'h18;
    localparam logic [2:0] GPR_PAGE = 3'h1;
    // Command register fields
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_SZ_LSB = 4;
    localparam int CMD_DST_LSB = 8;
    localparam int CMD_SRC_LSB = 12;
    localparam int CMD_IMM_BIT = 16;
    // Flag bit positions
    localparam int FLG_C = 0;
    localparam int FLG_V = 1;
    localparam int FLG_Z = 2;
    localparam int FLG_N = 3;
    // Status and config bit positions
    localparam int STAT_BUSY = 0;
    localparam int STAT_DZ = 1;
    localparam int CFG_SAT = 0;
    // Widths and constants
    localparam int MAC_W = 42;
    localparam int MACH_W = 10;
    localparam int NREG = 8;
    localparam logic [7:0] TSET_MASK = 8'h80;
    localparam logic [31:0] SAT_MAX = 32'h7FFFFFFF;
    localparam logic [31:0] SAT_MIN = 32'h80000000;
    // Reset values
    localparam logic [31:0] CMD_RST = 32'h00000000;
    localparam logic [31:0] WORD_RST = 32'h00000000;
    localparam logic [3:0] FLAG_RST = 4'h0;
    localparam logic [MAC_W-1:0] MAC_RST = 42'h000_0000_0000;

    typedef enum logic [1:0] {
        SZ_BYTE = 2'b00,
        SZ_WORD = 2'b01,
        SZ_LONG = 2'b10
    } amd_size_t;

    typedef enum logic [3:0] {
        OP_DIV = 4'b0000,
        OP_CMP = 4'b0001,
        OP_NEG = 4'b0010,
        OP_ZEXT = 4'b0011,
        OP_SEXT = 4'b0100,
        OP_TSET = 4'b0101,
        OP_MAC = 4'b0110,
        OP_ACLR = 4'b0111,
        OP_ALD = 4'b1000,
        OP_AST = 4'b1001
    } amd_op_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_FETCH = 3'b001,
        S_EXEC = 3'b010,
        S_TSET_RD = 3'b011,
        S_TSET_WR = 3'b100,
        S_MAC_A = 3'b101,
        S_MAC_B = 3'b110
    } amd_state_t;
endpackage

// ---- core/amd_regfile.sv ----
`timescale 1ns/10ps
module amd_regfile (
    input wire logic pclk, // Core clock
    input wire logic presetn, // Async reset, active low
    input wire logic [2:0] ra_addr, // Port A read index
    input wire logic [2:0] rb_addr, // Port B read index
    output logic [31:0] ra_data, // Port A registered data
    output logic [31:0] rb_data, // Port B registered data
    input wire logic we, // Write strobe
    input wire logic [2:0] waddr, // Write index
    input wire logic [31:0] wdata // Write data
);
    import amd_pkg::*;

    logic [31:0] mem_ff [NREG];

    ////////////////////////////////////////////////////////////////////////
    // Storage, cleared at reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NREG; i++) begin
                mem_ff[i] <= WORD_RST;
            end
        end else if (we) begin
            mem_ff[waddr] <= wdata;
        end
    end

    // Registered read ports
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ra_data <= WORD_RST;
            rb_data <= WORD_RST;
        end else begin
            ra_data <= mem_ff[ra_addr];
            rb_data <= mem_ff[rb_addr];
        end
    end
endmodule // amd_regfile

// ---- core/amd_datapath.sv ----
`timescale 1ns/10ps
module amd_datapath (
    input wire logic pclk, // Core clock
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped address
    output logic mem_req, // Memory request
    output logic mem_we, // Memory write
    output logic [31:0] mem_addr, // Memory byte address
    output logic [15:0] mem_wdata, // Memory write data
    input wire logic [15:0] mem_rdata, // Memory read data
    input wire logic mem_ack // Memory transfer done
);
    import amd_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Move the operand so its size's sign bit sits at bit 31
    function automatic logic [31:0] left_just(input logic [31:0] v, input amd_size_t sz);
        case (sz)
            SZ_BYTE: left_just = {v[7:0], 24'h000000};
            SZ_WORD: left_just = {v[15:0], 16'h0000};
            default: left_just = v;
        endcase
    endfunction

    // Subtraction flags {N,Z,V,C} at the given size
    function automatic logic [3:0] sub_flags(input logic [31:0] a, input logic [31:0] b,
                                             input amd_size_t sz);
        logic [31:0] al;
        logic [31:0] bl;
        logic [32:0] d;
        al = left_just(a, sz);
        bl = left_just(b, sz);
        d = {1'b0, al} - {1'b0, bl};
        sub_flags = {d[31], d[31:0] == 32'h0, (al[31] ^ bl[31]) & (al[31] ^ d[31]), d[32]};
    endfunction

    // Replace only the sized low part of a register
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input amd_size_t sz);
        case (sz)
            SZ_BYTE: merge = {old[31:8], nw[7:0]};
            SZ_WORD: merge = {old[31:16], nw[15:0]};
            default: merge = nw;
        endcase
    endfunction

    // Register hit at a given offset
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State and registers
    amd_state_t state_ff;
    amd_state_t nxt_state;
    logic [31:0] cmd_ff;
    logic cfg_sat_ff;
    logic [31:0] imm_ff;
    logic [3:0] flags_ff;
    logic divz_ff;
    logic [MAC_W-1:0] mac_ff;
    logic [15:0] opnd_ff;
    logic [31:0] prdata_ff;
    logic rd_lat_ff;
    logic [31:0] mem_addr_ff;
    logic [15:0] mem_wdata_ff;

    // Register file wiring
    logic [2:0] ra_addr;
    logic [31:0] ra_data;
    logic [31:0] rb_data;
    logic rf_we;
    logic [2:0] rf_waddr;
    logic [31:0] rf_wdata;

    // Command fields
    amd_op_t op;
    amd_size_t sz;
    logic [2:0] dst;
    logic [2:0] src;
    assign op = amd_op_t'(cmd_ff[CMD_OP_LSB +: 4]);
    assign sz = amd_size_t'(cmd_ff[CMD_SZ_LSB +: 2]);
    assign dst = cmd_ff[CMD_DST_LSB +: 3];
    assign src = cmd_ff[CMD_SRC_LSB +: 3];

    ////////////////////////////////////////////////////////////////////////
    // APB slave
    logic busy;
    logic hit_cmd, hit_cfg, hit_imm, hit_flag, hit_stat, hit_mach, hit_macl, hit_gpr;
    logic unmapped;
    logic hold;
    logic was_busy_ff;
    logic apb_acc;
    logic apb_wr;
    logic [31:0] rd_mux;

    assign busy = (state_ff != S_IDLE);
    assign hit_cmd = hit(paddr, CMD_OFS);
    assign hit_cfg = hit(paddr, CFG_OFS);
    assign hit_imm = hit(paddr, IMM_OFS);
    assign hit_flag = hit(paddr, FLAG_OFS);
    assign hit_stat = hit(paddr, STAT_OFS);
    assign hit_mach = hit(paddr, MACH_OFS);
    assign hit_macl = hit(paddr, MACL_OFS);
    assign hit_gpr = (paddr[7:5] == GPR_PAGE) && (paddr[1:0] == 2'h0);
    assign unmapped = !(hit_cmd | hit_cfg | hit_imm | hit_flag | hit_stat |
                        hit_mach | hit_macl | hit_gpr);
    // Only status may be reached while an operation runs and one cycle after,
    // so the registered file read port catches up with the bus address
    assign hold = (busy | was_busy_ff) & !hit_stat;
    assign apb_acc = psel & penable;
    // Writes finish in the first access cycle, reads in the second
    assign pready = apb_acc & !hold & (pwrite | rd_lat_ff);
    assign pslverr = pready & unmapped;
    assign apb_wr = pready & pwrite & !unmapped;
    assign prdata = prdata_ff;
    // Register file port A serves the bus when idle
    assign ra_addr = busy ? dst : paddr[4:2];

    // Read multiplexer
    always_comb begin
        rd_mux = WORD_RST;
        if (hit_cmd) rd_mux = cmd_ff;
        if (hit_cfg) rd_mux[CFG_SAT] = cfg_sat_ff;
        if (hit_imm) rd_mux = imm_ff;
        if (hit_flag) rd_mux[3:0] = flags_ff;
        if (hit_stat) rd_mux[STAT_DZ:STAT_BUSY] = {divz_ff, busy};
        if (hit_mach) rd_mux[MACH_W-1:0] = mac_ff[MAC_W-1:32];
        if (hit_macl) rd_mux = mac_ff[31:0];
        if (hit_gpr) rd_mux = ra_data;
    end

    // Read data capture, one wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_lat_ff <= 1'b0;
            prdata_ff <= WORD_RST;
        end else if (pready) begin
            rd_lat_ff <= 1'b0;
        end else if (apb_acc && !pwrite && !hold) begin
            rd_lat_ff <= 1'b1;
            prdata_ff <= rd_mux;
        end
    end

    // Software-written control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_ff <= CMD_RST;
            cfg_sat_ff <= 1'b0;
            imm_ff <= WORD_RST;
        end else if (apb_wr) begin
            if (hit_cmd) cmd_ff <= pwdata;
            if (hit_cfg) cfg_sat_ff <= pwdata[CFG_SAT];
            if (hit_imm) imm_ff <= pwdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Execution datapath
    logic [31:0] a;
    logic [31:0] b;
    logic long_ext;
    logic [31:0] zx_res;
    logic [31:0] sx_res;
    logic signed [31:0] dvd;
    logic signed [31:0] dvs;
    logic signed [31:0] quo;
    logic signed [31:0] rem;
    logic dz;
    logic [31:0] div_res;
    logic [3:0] ext_fl;
    logic [31:0] exec_res;
    logic exec_we;
    logic [3:0] exec_fl;
    logic exec_fl_we;

    assign a = ra_data;
    assign b = cmd_ff[CMD_IMM_BIT] ? imm_ff : rb_data;
    assign long_ext = (sz == SZ_LONG);
    // Extensions keep the low half of the sized operand and rebuild its upper half
    assign zx_res = long_ext ? {16'h0000, a[15:0]} : {a[31:16], 8'h00, a[7:0]};
    assign sx_res = long_ext ? {{16{a[15]}}, a[15:0]} :
                    {a[31:16], {8{a[7]}}, a[7:0]};

    // Signed divide, word form unless byte is asked for
    always_comb begin
        if (sz == SZ_BYTE) begin
            dvd = {{16{a[15]}}, a[15:0]};
            dvs = {{24{b[7]}}, b[7:0]};
        end else begin
            dvd = a;
            dvs = {{16{b[15]}}, b[15:0]};
        end
        dz = (dvs == 32'sh0);
        // Guard against a zero divisor; result is discarded then
        quo = dvd / (dz ? 32'sh1 : dvs);
        rem = dvd % (dz ? 32'sh1 : dvs);
        if (sz == SZ_BYTE) div_res = {a[31:16], rem[7:0], quo[7:0]};
        else div_res = {rem[15:0], quo[15:0]};
    end

    // Extension flags: N and Z of result, V cleared, C kept
    always_comb begin
        ext_fl = sub_flags(op == OP_ZEXT ? zx_res : sx_res, WORD_RST,
                           long_ext ? SZ_LONG : SZ_WORD);
        ext_fl[FLG_V] = 1'b0;
        ext_fl[FLG_C] = flags_ff[FLG_C];
    end

    // Result, write enable and flags per operation
    always_comb begin
        exec_res = a;
        exec_we = 1'b0;
        exec_fl = flags_ff;
        exec_fl_we = 1'b0;
        case (op)
            OP_DIV: begin
                exec_res = div_res;
                exec_we = !dz;
                exec_fl[FLG_N] = (sz == SZ_BYTE) ? quo[7] : quo[15];
                exec_fl[FLG_Z] = dz;
                exec_fl_we = 1'b1;
            end
            OP_CMP: begin
                exec_fl = sub_flags(a, b, sz);
                exec_fl_we = 1'b1;
            end
            OP_NEG: begin
                exec_res = merge(a, WORD_RST - a, sz);
                exec_we = 1'b1;
                exec_fl = sub_flags(WORD_RST, a, sz);
                exec_fl_we = 1'b1;
            end
            OP_ZEXT: begin
                exec_res = zx_res;
                exec_we = 1'b1;
                exec_fl = ext_fl;
                exec_fl_we = 1'b1;
            end
            OP_SEXT: begin
                exec_res = sx_res;
                exec_we = 1'b1;
                exec_fl = ext_fl;
                exec_fl_we = 1'b1;
            end
            OP_AST: begin
                exec_res = mac_ff[31:0];
                exec_we = 1'b1;
            end
            default: begin
                exec_we = 1'b0;
            end
        endcase
    end

    // Register file write: bus when idle, datapath in execute
    always_comb begin
        rf_we = 1'b0;
        rf_waddr = dst;
        rf_wdata = exec_res;
        if (state_ff == S_IDLE) begin
            rf_we = apb_wr & hit_gpr;
            rf_waddr = paddr[4:2];
            rf_wdata = pwdata;
        end else if (state_ff == S_EXEC) begin
            rf_we = exec_we;
        end
    end

    amd_regfile u_regfile (
        .pclk(pclk),
        .presetn(presetn),
        .ra_addr(ra_addr),
        .rb_addr(src),
        .ra_data(ra_data),
        .rb_data(rb_data),
        .we(rf_we),
        .waddr(rf_waddr),
        .wdata(rf_wdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            S_IDLE: if (apb_wr && hit_cmd) nxt_state = S_FETCH;
            S_FETCH: nxt_state = S_EXEC;
            S_EXEC: begin
                if (op == OP_TSET) nxt_state = S_TSET_RD;
                else if (op == OP_MAC) nxt_state = S_MAC_A;
                else nxt_state = S_IDLE;
            end
            S_TSET_RD: if (mem_ack) nxt_state = S_TSET_WR;
            S_TSET_WR: if (mem_ack) nxt_state = S_IDLE;
            S_MAC_A: if (mem_ack) nxt_state = S_MAC_B;
            S_MAC_B: if (mem_ack) nxt_state = S_IDLE;
            default: nxt_state = S_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) state_ff <= S_IDLE;
        else state_ff <= nxt_state;
    end

    // Busy delayed by one cycle, stretches the bus hold
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) was_busy_ff <= 1'b0;
        else was_busy_ff <= busy;
    end

    ////////////////////////////////////////////////////////////////////////
    // Memory port
    assign mem_req = (state_ff == S_TSET_RD) || (state_ff == S_TSET_WR) ||
                     (state_ff == S_MAC_A) || (state_ff == S_MAC_B);
    assign mem_we = (state_ff == S_TSET_WR);
    assign mem_addr = mem_addr_ff;
    assign mem_wdata = mem_wdata_ff;

    // Address and write data for memory phases
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_addr_ff <= WORD_RST;
            mem_wdata_ff <= 16'h0000;
        end else if (state_ff == S_EXEC) begin
            // Pointer is the destination for test-and-set, source for MAC
            mem_addr_ff <= (op == OP_TSET) ? a : rb_data;
        end else if (state_ff == S_TSET_RD && mem_ack) begin
            mem_wdata_ff <= {8'h00, mem_rdata[7:0] | TSET_MASK};
        end else if (state_ff == S_MAC_A && mem_ack) begin
            mem_addr_ff <= a;
        end
    end

    // First multiplier operand
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) opnd_ff <= 16'h0000;
        else if (state_ff == S_MAC_A && mem_ack) opnd_ff <= mem_rdata;
    end

    ////////////////////////////////////////////////////////////////////////
    // Accumulator
    logic signed [31:0] prod;
    logic [32:0] sat_sum;
    logic [MAC_W-1:0] mac_next;

    always_comb begin
        prod = $signed(opnd_ff) * $signed(mem_rdata);
        sat_sum = {mac_ff[31], mac_ff[31:0]} + {prod[31], prod};
        if (!cfg_sat_ff) begin
            mac_next = mac_ff + {{(MAC_W-32){prod[31]}}, prod};
        end else if (sat_sum[32] != sat_sum[31]) begin
            // Clamp to the signed 32-bit limit on overflow
            mac_next = sat_sum[32] ? {{(MAC_W-32){1'b1}}, SAT_MIN} :
                       {{(MAC_W-32){1'b0}}, SAT_MAX};
        end else begin
            mac_next = {{(MAC_W-32){sat_sum[31]}}, sat_sum[31:0]};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mac_ff <= MAC_RST;
        end else if (state_ff == S_EXEC && op == OP_ACLR) begin
            mac_ff <= MAC_RST;
        end else if (state_ff == S_EXEC && op == OP_ALD) begin
            mac_ff <= {{(MAC_W-32){b[31]}}, b};
        end else if (state_ff == S_MAC_B && mem_ack) begin
            mac_ff <= mac_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Condition flags and divide status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_ff <= FLAG_RST;
        end else if (apb_wr && hit_flag) begin
            flags_ff <= pwdata[3:0];
        end else if (state_ff == S_EXEC && exec_fl_we) begin
            flags_ff <= exec_fl;
        end else if (state_ff == S_TSET_RD && mem_ack) begin
            flags_ff <= sub_flags({24'h000000, mem_rdata[7:0]}, WORD_RST, SZ_BYTE);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) divz_ff <= 1'b0;
        else if (state_ff == S_EXEC && op == OP_DIV) divz_ff <= dz;
    end
endmodule // amd_datapath

// ---- dv/amd_datapath_asserts.sv ----
`timescale 1ns/10ps
module amd_datapath_asserts (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, active low
    input wire logic psel, // Select
    input wire logic penable, // Enable
    input wire logic pwrite, // Direction
    input wire logic [7:0] paddr, // Address
    input wire logic [31:0] pwdata, // Write data
    input wire logic [31:0] prdata, // Read data
    input wire logic pready, // Ready
    input wire logic pslverr, // Error
    input wire logic mem_req, // Memory request
    input wire logic mem_we, // Memory write
    input wire logic [31:0] mem_addr, // Memory address
    input wire logic [15:0] mem_wdata, // Memory write data
    input wire logic [15:0] mem_rdata, // Memory read data
    input wire logic mem_ack // Memory done
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////
    // Bus handshake and refusals
    a_rdy_in_access: assert property (pready |-> psel && penable)
        else $error("ready outside access phase");
    a_err_with_rdy: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_bad_addr_err: assert property (pready && (paddr[1:0] != 2'b00 || paddr == 8'h1C) |-> pslverr)
        else $error("bad address not refused");
    a_err_read_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    ////////////////////////////////////////
    // Memory port
    a_mem_hold: assert property (mem_req && !mem_ack |=>
        mem_req && $stable(mem_addr) && $stable(mem_we) && $stable(mem_wdata))
        else $error("memory request changed before ack");
    a_we_with_req: assert property (mem_we |-> mem_req)
        else $error("write strobe without request");
    a_read_first: assert property ($rose(mem_req) |-> !mem_we)
        else $error("memory sequence began with a write");
    a_tset_same_addr: assert property ($rose(mem_we) |->
        $stable(mem_addr) && $past(mem_ack))
        else $error("write back not after read at same address");
    a_tset_msb_set: assert property (mem_req && mem_we |-> mem_wdata[7])
        else $error("written byte lacks top bit");
endmodule // amd_datapath_asserts
bind amd_datapath amd_datapath_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata,
    .mem_ack);

// ---- dv/arith_mac_datapath_tb.sv ----
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module arith_mac_datapath_tb;
    import amd_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mem_req, mem_we, mem_ack, rerr;
    logic [7:0] paddr, wbyte;
    logic [31:0] pwdata, prdata, mem_addr, rdat;
    logic [15:0] mem_wdata, mem_rdata;
    int failures, n_tests;
    amd_datapath dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack);
    // Clock
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // Memory side: one wait per phase, echoes address, noise when idle
    always @(posedge pclk) begin
        mem_ack <= presetn && mem_req && !mem_ack;
        mem_rdata <= (mem_req || !presetn) ? mem_addr[15:0] : ~mem_rdata;
        if (mem_req && mem_we && mem_ack) wbyte <= mem_wdata[7:0];
    end
    ////////////////////////////////////////
    task print_verdict;
        $display("Checks %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // One APB transfer, held until ready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 300);
        if (pready !== 1'b1) begin
            failures++;
            print_verdict;
        end
        // Answer taken at the ready edge, request released right after it
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(nm, e, rdat);
    endtask
    task op(input amd_op_t o, input amd_size_t s, input int dr, input int sr, input logic im);
        wr(CMD_OFS, {15'h0, im, 1'b0, sr[2:0], 1'b0, dr[2:0], 2'b00, s, o});
    endtask
    function logic [7:0] ga(input int n);
        return 8'h20 + 8'(4 * n);
    endfunction
    // Expected N,Z,V,C of a - b at width w
    function logic [31:0] subf(input logic [31:0] a, input logic [31:0] b, input int w);
        logic [32:0] r;
        logic [31:0] m;
        m = (w == 32) ? 32'hFFFFFFFF : ((32'h1 << w) - 32'h1);
        r = {1'b0, a & m} - {1'b0, b & m};
        return {28'h0, r[w-1], (r[31:0] & m) == 32'h0, (a[w-1] != b[w-1]) && (r[w-1] != a[w-1]),
            r[32]};
    endfunction
    ////////////////////////////////////////
    task t_bus;
        rd_chk("cmd rst", CMD_OFS, CMD_RST);
        rd_chk("mach rst", MACH_OFS, 32'h0);
        apb(1'b0, 8'h1C, 32'h0);
        `CHK("unmapped err", 1'b1, rerr);
        apb(1'b1, 8'h02, 32'h5);
        `CHK("misaligned err", 1'b1, rerr);
        wr(MACL_OFS, 32'h1234);
        rd_chk("macl ro", MACL_OFS, 32'h0);
        wr(FLAG_OFS, 32'hF);
        rd_chk("flags rw", FLAG_OFS, 32'hF);
        wr(FLAG_OFS, 32'h0);
    endtask
    task t_div;
        wr(ga(0), 32'h1234FF9C);
        wr(ga(1), 32'h7);
        wr(ga(2), 32'h000186A0);
        wr(ga(3), 32'hFFF9);
        op(OP_DIV, SZ_BYTE, 0, 1, 1'b0);
        rd_chk("div byte", ga(0), 32'h1234FEF2);
        rd_chk("div flags", FLAG_OFS, 32'h8);
        op(OP_DIV, SZ_WORD, 2, 3, 1'b0);
        rd_chk("div word", ga(2), 32'h0005C833);
        op(OP_DIV, SZ_WORD, 2, 4, 1'b0);
        rd_chk("div zero", ga(2), 32'h0005C833);
        rd_chk("div zero stat", STAT_OFS, 32'h2);
    endtask
    task t_cmp_neg;
        wr(ga(5), 32'h80000000);
        wr(IMM_OFS, 32'h1);
        op(OP_CMP, SZ_LONG, 5, 0, 1'b1);
        rd_chk("cmp long", FLAG_OFS, subf(32'h80000000, 32'h1, 32));
        rd_chk("cmp keep", ga(5), 32'h80000000);
        wr(ga(6), 32'h10);
        wr(ga(7), 32'h20);
        op(OP_CMP, SZ_BYTE, 6, 7, 1'b0);
        rd_chk("cmp byte", FLAG_OFS, subf(32'h10, 32'h20, 8));
        op(OP_CMP, SZ_WORD, 7, 7, 1'b0);
        rd_chk("cmp word", FLAG_OFS, 32'h4);
        wr(ga(6), 32'h12345680);
        op(OP_NEG, SZ_BYTE, 6, 0, 1'b0);
        rd_chk("neg byte", ga(6), 32'h12345680);
        rd_chk("neg flags", FLAG_OFS, subf(32'h0, 32'h80, 8));
        op(OP_NEG, SZ_WORD, 6, 0, 1'b0);
        rd_chk("neg word", ga(6), 32'h1234A980);
        op(OP_NEG, SZ_LONG, 4, 0, 1'b0);
        rd_chk("neg long", FLAG_OFS, subf(32'h0, 32'h0, 32));
    endtask
    task t_ext;
        wr(ga(1), 32'hAAAA12F0);
        op(OP_ZEXT, SZ_WORD, 1, 0, 1'b0);
        rd_chk("zext word", ga(1), 32'hAAAA00F0);
        op(OP_SEXT, SZ_WORD, 1, 0, 1'b0);
        rd_chk("sext word", ga(1), 32'hAAAAFFF0);
        op(OP_ZEXT, SZ_LONG, 1, 0, 1'b0);
        rd_chk("zext long", ga(1), 32'h0000FFF0);
        op(OP_SEXT, SZ_LONG, 1, 0, 1'b0);
        rd_chk("sext long", ga(1), 32'hFFFFFFF0);
        rd_chk("ext flags", FLAG_OFS, 32'h8);
    endtask
    // Pointer register r holds p; byte seen is p[7:0]
    task tset1(input int r, input logic [31:0] p, input logic [31:0] f, input logic [7:0] b);
        wr(ga(r), p);
        op(OP_TSET, SZ_BYTE, r, 0, 1'b0);
        rd_chk("tset flags", FLAG_OFS, f);
        `CHK("tset byte", b, wbyte);
    endtask
    task t_mac;
        wr(IMM_OFS, 32'h80000000);
        op(OP_ALD, SZ_LONG, 0, 0, 1'b1);
        rd_chk("ld mach", MACH_OFS, 32'h3FF);
        op(OP_ACLR, SZ_LONG, 0, 0, 1'b0);
        rd_chk("clr mach", MACH_OFS, 32'h0);
        rd_chk("clr macl", MACL_OFS, 32'h0);
        wr(ga(1), 32'h7FFF);
        wr(ga(2), 32'h7FFF);
        repeat (3) op(OP_MAC, SZ_LONG, 2, 1, 1'b0);
        rd_chk("mac macl", MACL_OFS, 32'hBFFD0003);
        rd_chk("mac mach", MACH_OFS, 32'h0);
        wr(CFG_OFS, 32'h1);
        wr(IMM_OFS, 32'h7FFF0000);
        op(OP_ALD, SZ_LONG, 0, 0, 1'b1);
        op(OP_MAC, SZ_LONG, 2, 1, 1'b0);
        rd_chk("sat max", MACL_OFS, SAT_MAX);
        wr(IMM_OFS, SAT_MIN);
        op(OP_ALD, SZ_LONG, 0, 0, 1'b1);
        wr(ga(2), 32'h8001);
        op(OP_MAC, SZ_LONG, 2, 1, 1'b0);
        rd_chk("sat min h", MACH_OFS, 32'h3FF);
        op(OP_AST, SZ_LONG, 3, 0, 1'b0);
        rd_chk("st mac", ga(3), SAT_MIN);
    endtask
    ////////////////////////////////////////
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = 32'h0;
        failures = 0;
        n_tests = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_bus;
        t_div;
        t_cmp_neg;
        t_ext;
        tset1(4, 32'h45, 32'h0, 8'hC5);
        tset1(0, 32'h100, 32'h4, 8'h80);
        tset1(5, 32'h185, 32'h8, 8'h85);
        t_mac;
        print_verdict;
    end
endmodule // arith_mac_datapath_tb
